// *** hw/pgp_top.sv ***
// What this block does
// - bits 7:4 set debounce: 0000 is 320 ms, 1010 is 600 ms, 1111 none
// - primary good waits until all seven conditions normal for the debounce time
// - on request withdrawn, primary good falls only after the debounce time
// - bit 3 low: any flag sets secondary good; high: only unignored flags
// - bit 2 high makes the external flag input active low
// - bit 1 high makes the fet gate output active low
// - bit 0 high makes the supply-on request input active low
`timescale 1ns/100ps
`default_nettype none
`include "pgp_defines.svh"

module pgp_top #(
  parameter int TICK_CYCLES = `PGP_CLK_HZ / `PGP_MS_PER_S
)
(
  // clock and reset
  input  wire logic             hclk,
  input  wire logic             hresetn,
  // ahb-lite slave
  input  wire logic             hsel,
  input  wire logic [31:0]      haddr,
  input  wire logic [1:0]       htrans,
  input  wire logic             hwrite,
  input  wire logic [2:0]       hsize,
  input  wire logic [31:0]      hwdata,
  input  wire logic             hready,
  output var  logic             hreadyout,
  output var  logic             hresp,
  output var  logic [31:0]      hrdata,
  // pins from outside, synchronised here
  input  wire pgp_pkg::pgp_sup_t sup_ok,
  input  wire logic             supply_on_request,
  input  wire logic             external_flag_input,
  // same-clock inputs from the fault logic
  input  wire logic [7:0]       fault_flags,
  input  wire logic [7:0]       flag_ignored,
  input  wire logic             gate_on_request,
  // pin outputs
  output var  logic             power_good_primary,
  output var  logic             power_good_secondary,
  output var  logic             fet_gate,
  output var  logic             flag_in_active,
  // interrupt
  output var  logic             irq
);

  localparam int PIN_W = `PGP_PIN_W;

  // pin synchroniser: three stages, value moves when stages two and three agree
  logic [PIN_W-1:0] pin_raw;
  logic [PIN_W-1:0] s1_reg;
  logic [PIN_W-1:0] s2_reg;
  logic [PIN_W-1:0] s3_reg;
  logic [PIN_W-1:0] pin_reg;

  assign pin_raw = {sup_ok, supply_on_request, external_flag_input};

  genvar gi;
  generate
    for (gi = 0; gi < PIN_W; gi++)
    begin : g_sync
      always_ff @(posedge hclk or negedge hresetn)
      begin
        if (!hresetn)
        begin
          s1_reg[gi]  <= 1'b0;
          s2_reg[gi]  <= 1'b0;
          s3_reg[gi]  <= 1'b0;
          pin_reg[gi] <= 1'b0;
        end
        else
        begin
          s1_reg[gi] <= pin_raw[gi];
          s2_reg[gi] <= s1_reg[gi];
          s3_reg[gi] <= s2_reg[gi];
          if (s2_reg[gi] == s3_reg[gi])
            pin_reg[gi] <= s3_reg[gi];
        end
      end
    end
  endgenerate

  // registers
  logic [7:0]            pol_reg;
  logic [`PGP_EV_W-1:0]  status_reg;
  logic [`PGP_EV_W-1:0]  status_next;
  logic [`PGP_EV_W-1:0]  mask_reg;
  pgp_pkg::pgp_aphase_t  aph_reg;
  pgp_pkg::pgp_aphase_t  aph_next;
  logic [31:0]           rdata_next;

  // polarity fields
  wire [3:0] deb_code   = pol_reg[`PGP_DEB_MSB:`PGP_DEB_LSB];
  wire       pg2_sel    = pol_reg[`PGP_PG2_SEL_BIT];
  wire       external_flag_input_inv = pol_reg[`PGP_EXTERNAL_FLAG_INPUT_BIT];
  wire       gate_inv   = pol_reg[`PGP_GATE_BIT];
  wire       son_inv    = pol_reg[`PGP_SON_BIT];

  // synchronised pins, polarity applied
  pgp_pkg::pgp_sup_t sup_sync;
  wire son_pin    = pin_reg[`PGP_PIN_SON];
  wire external_flag_input_pin = pin_reg[`PGP_PIN_FLAG];
  assign sup_sync = pin_reg[PIN_W-1:`PGP_PIN_SUP_LSB];
  wire son_active = son_pin ^ son_inv;
  wire external_flag_input_on  = external_flag_input_pin ^ external_flag_input_inv;
  wire all_ok     = &sup_sync;

  // debounce delay lookup; unlisted codes fall back to the 320 ms default
  logic [9:0] deb_ms;
  assign deb_ms = (deb_code == `PGP_CODE_NONE) ? `PGP_DEB_NONE_MS :
                  (deb_code == `PGP_CODE_600)  ? `PGP_DEB_600_MS  :
                  (deb_code == `PGP_CODE_200)  ? `PGP_DEB_200_MS  :
                                                 `PGP_DEB_320_MS;

  // ms tick divider; restarted on entering a wait so each ms is whole
  pgp_pkg::pgp_state_t state_reg;
  pgp_pkg::pgp_state_t state_next;
  logic [31:0] div_reg;
  logic [9:0]  ms_reg;
  wire waiting  = (state_reg == pgp_pkg::PGP_WAIT_ON) ||
                  (state_reg == pgp_pkg::PGP_WAIT_OFF);
  wire ms_tick  = waiting && (div_reg == 32'(TICK_CYCLES - 1));
  wire deb_done = (ms_reg >= deb_ms);
  wire restart  = (state_next != state_reg);

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      div_reg <= 32'h0000_0000;
    else if (!waiting || restart || ms_tick)
      div_reg <= 32'h0000_0000;
    else
      div_reg <= div_reg + 32'h0000_0001;
  end

  // elapsed debounce time in ms
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      ms_reg <= 10'h000;
    else if (restart || !waiting)
      ms_reg <= 10'h000;
    else if (ms_tick && !deb_done)
      ms_reg <= ms_reg + 10'h001;
  end

  // primary power good sequencing
  always_comb
  begin
    state_next = state_reg;
    unique case (state_reg)
      pgp_pkg::PGP_OFF:
        if (all_ok && son_active)
          state_next = (deb_ms == `PGP_DEB_NONE_MS) ? pgp_pkg::PGP_ON
                                                    : pgp_pkg::PGP_WAIT_ON;
      pgp_pkg::PGP_WAIT_ON:
        if (!(all_ok && son_active))
          state_next = pgp_pkg::PGP_OFF;
        else if (deb_done)
          state_next = pgp_pkg::PGP_ON;
      pgp_pkg::PGP_ON:
        if (!all_ok)
          state_next = pgp_pkg::PGP_OFF;       // a fault drops it at once
        else if (!son_active)
          state_next = (deb_ms == `PGP_DEB_NONE_MS) ? pgp_pkg::PGP_OFF
                                                    : pgp_pkg::PGP_WAIT_OFF;
      pgp_pkg::PGP_WAIT_OFF:
        if (!all_ok)
          state_next = pgp_pkg::PGP_OFF;
        else if (son_active)
          state_next = pgp_pkg::PGP_ON;        // request came back in time
        else if (deb_done)
          state_next = pgp_pkg::PGP_OFF;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      state_reg <= pgp_pkg::PGP_OFF;
    else
      state_reg <= state_next;
  end

  // output pins
  wire pg1_next = (state_next == pgp_pkg::PGP_ON) ||
                  (state_next == pgp_pkg::PGP_WAIT_OFF);
  wire [8:0] all_flags  = {external_flag_input_on, fault_flags};
  wire [8:0] flag_allow = {1'b1, ~flag_ignored};
  wire pg2_next = pg2_sel ? |(all_flags & flag_allow)
                          : |all_flags;
  wire gate_next = gate_on_request ^ gate_inv;

  // power good pins; primary follows the sequencer state, so it never glitches
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      power_good_primary   <= 1'b0;
      power_good_secondary <= 1'b0;
    end
    else
    begin
      power_good_primary   <= pg1_next;
      power_good_secondary <= pg2_next;
    end
  end

  // polarity-adjusted pins, one cycle behind their sources
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      fet_gate       <= 1'b0;
      flag_in_active <= 1'b0;
    end
    else
    begin
      fet_gate       <= gate_next;
      flag_in_active <= external_flag_input_on;
    end
  end

  // events; son_prev lets a lost request show even if debounce hides it
  logic son_prev_reg;
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      son_prev_reg <= 1'b0;
    else
      son_prev_reg <= son_active;
  end

  logic [`PGP_EV_W-1:0] ev;
  assign ev[`PGP_EV_PG1_RISE] = pg1_next && !power_good_primary;
  assign ev[`PGP_EV_PG1_FALL] = !pg1_next && power_good_primary;
  assign ev[`PGP_EV_PG2_RISE] = pg2_next && !power_good_secondary;
  assign ev[`PGP_EV_SON_LOST] = son_prev_reg && !son_active;

  // ahb address phase decode; zero wait states, always okay
  wire ap_take = hsel && htrans[1] && hready;
  assign aph_next.ofs = haddr[`PGP_OFS_MSB:0];
  assign aph_next.wr  = hwrite;
  assign aph_next.vld = ap_take;
  wire unused_ok = &{1'b0, haddr[31:8], hsize};

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      aph_reg <= '0;
    else
      aph_reg <= aph_next;
  end

  // data phase write strobes
  wire wr_dp     = aph_reg.vld && aph_reg.wr;
  wire wr_pol    = wr_dp && (aph_reg.ofs == `PGP_OFS_POLARITY);
  wire wr_status = wr_dp && (aph_reg.ofs == `PGP_OFS_STATUS);
  wire wr_mask   = wr_dp && (aph_reg.ofs == `PGP_OFS_MASK);

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      pol_reg  <= `PGP_POL_RESET;
      mask_reg <= '0;
    end
    else
    begin
      if (wr_pol)
        pol_reg <= hwdata[7:0];
      if (wr_mask)
        mask_reg <= hwdata[`PGP_EV_W-1:0];
    end
  end

  // sticky status: write one clears, a same-cycle event wins
  always_comb
  begin
    status_next = status_reg;
    if (wr_status)
      status_next = status_next & ~hwdata[`PGP_EV_W-1:0];
    status_next = status_next | ev;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      status_reg <= '0;
    else
      status_reg <= status_next;
  end

  // read address decode, taken from the live address phase
  wire rd_take   = ap_take && !hwrite;
  wire rd_pol    = aph_next.ofs == `PGP_OFS_POLARITY;
  wire rd_status = aph_next.ofs == `PGP_OFS_STATUS;
  wire rd_mask   = aph_next.ofs == `PGP_OFS_MASK;
  wire rd_state  = aph_next.ofs == `PGP_OFS_STATE;

  // state word: sequencer state, request, flag, then the seven conditions
  wire [31:0] state_word = {21'h0_0000,       // unused upper bits
                            sup_sync,         // bits 10:4
                            external_flag_input_on,        // bit 3
                            son_active,       // bit 2
                            state_reg};       // bits 1:0

  // read mux, sampled in the address phase so hrdata is a flop output;
  // a read right after a write to the same register sees the old value, except status, which reads status_next
  assign rdata_next =
    !rd_take   ? 32'h0000_0000 :
    rd_pol     ? {24'h00_0000, pol_reg} :
    rd_status  ? {28'h000_0000, status_next} :
    rd_mask    ? {28'h000_0000, mask_reg} :
    rd_state   ? state_word :
                 32'h0000_0000;

  // bus response: zero wait states, always okay
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      hrdata    <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
    else
    begin
      hrdata    <= rdata_next;
      hreadyout <= 1'b1;
      hresp     <= unused_ok;   // constant zero: okay on every access
    end
  end

  // level interrupt; uses status_next so a clear drops it on the same edge
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      irq <= 1'b0;
    else
      irq <= |(status_next & mask_reg);
  end

endmodule : pgp_top

`default_nettype wire

// *** common/pgp_defines.svh ***
`ifndef PGP_DEFINES_SVH
`define PGP_DEFINES_SVH

// register byte offsets
`define PGP_OFS_POLARITY  8'h00
`define PGP_OFS_STATUS    8'h04
`define PGP_OFS_MASK      8'h08
`define PGP_OFS_STATE     8'h0c
`define PGP_OFS_MSB       7
`define PGP_POL_RESET     8'h00

// fields of pin_polarity_setting
`define PGP_DEB_MSB       7
`define PGP_DEB_LSB       4
`define PGP_PG2_SEL_BIT   3
`define PGP_EXTERNAL_FLAG_INPUT_BIT    2
`define PGP_GATE_BIT      1
`define PGP_SON_BIT       0

// debounce codes and their delays in ms
`define PGP_CODE_320      4'h0
`define PGP_CODE_200      4'h1
`define PGP_CODE_600      4'ha
`define PGP_CODE_NONE     4'hf
`define PGP_DEB_320_MS    10'd320
`define PGP_DEB_200_MS    10'd200
`define PGP_DEB_600_MS    10'd600
`define PGP_DEB_NONE_MS   10'd0

// timing
`define PGP_CLK_HZ        250000000
`define PGP_MS_PER_S      1000

// status bits
`define PGP_EV_PG1_RISE   0
`define PGP_EV_PG1_FALL   1
`define PGP_EV_PG2_RISE   2
`define PGP_EV_SON_LOST   3
`define PGP_EV_W          4

// synchroniser bit positions
`define PGP_PIN_W         9
`define PGP_PIN_SUP_LSB   2
`define PGP_PIN_SON       1
`define PGP_PIN_FLAG      0

`endif

// *** common/pgp_pkg.sv ***
`default_nettype none

package pgp_pkg;

  // supervised conditions, each high while within normal limits
  typedef struct packed {
    logic supply;
    logic sense_one_fast_oc;
    logic sense_one_acc_oc;
    logic sense_two_acc_oc;
    logic under_voltage;
    logic local_over_voltage;
    logic load_over_voltage;
  } pgp_sup_t;

  // captured ahb address phase
  typedef struct packed {
    logic [7:0] ofs;
    logic       wr;
    logic       vld;
  } pgp_aphase_t;

  typedef enum logic [1:0] {
    PGP_OFF,
    PGP_WAIT_ON,
    PGP_ON,
    PGP_WAIT_OFF
  } pgp_state_t;

endpackage : pgp_pkg

`default_nettype wire

// *** sim/pgp_top_asserts.sv ***
`timescale 1ns/100ps
`default_nettype none
module pgp_top_asserts (
  // clock, reset and bus
  input wire logic              hclk,
  input wire logic              hresetn,
  input wire logic              hsel,
  input wire logic [1:0]        htrans,
  input wire logic              hwrite,
  input wire logic              hready,
  input wire logic              hreadyout,
  input wire logic              hresp,
  input wire logic [31:0]       hrdata,
  // pins and fault logic
  input wire pgp_pkg::pgp_sup_t sup_ok,
  input wire logic              external_flag_input,
  input wire logic [7:0]        fault_flags,
  input wire logic [7:0]        flag_ignored,
  input wire logic              gate_on_request,
  // outputs watched
  input wire logic              power_good_primary,
  input wire logic              power_good_secondary,
  input wire logic              fet_gate,
  input wire logic              flag_in_active
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  // a read is taken only on this qualifier
  wire rd_take = hsel && htrans[1] && hready && !hwrite;

  // a supervised condition leaving normal limits
  sequence s_cond_lost;
    $fell(&sup_ok);
  endsequence

  property p_rdy; hreadyout; endproperty
  property p_okay; !hresp; endproperty
  property p_idle_rd; !rd_take |=> hrdata == 32'h0; endproperty
  property p_pg1_drop;
    s_cond_lost |-> ##[1:6] !power_good_primary;
  endproperty
  // sync takes several edges, so good needs conditions seen 3 back
  property p_pg1_rise;
    $rose(power_good_primary) |-> (&sup_ok) && $past(&sup_ok, 3);
  endproperty
  property p_gate; $changed(gate_on_request) |=> $changed(fet_gate); endproperty
  property p_pg2;
    |(fault_flags & ~flag_ignored) |=> power_good_secondary;
  endproperty
  property p_flag;
    $changed(external_flag_input) |-> ##[2:6] $changed(flag_in_active);
  endproperty

  a_rdy: assert property (p_rdy) else $error("hreadyout low");
  a_okay: assert property (p_okay) else $error("hresp not okay");
  a_idle_rd: assert property (p_idle_rd) else $error("hrdata not zero");
  a_pg1_drop: assert property (p_pg1_drop)
    else $error("primary good kept after fault");
  a_pg1_rise: assert property (p_pg1_rise)
    else $error("primary good rose early");
  a_gate: assert property (p_gate)
    else $error("gate did not follow request");
  a_pg2: assert property (p_pg2)
    else $error("secondary good missing");
  a_flag: assert property (p_flag)
    else $error("flag active did not follow pin");
endmodule : pgp_top_asserts
`default_nettype wire

// *** sim/pgp_far_side.sv ***
`timescale 1ns/100ps
`default_nettype none
module pgp_far_side (
  // states requested by the bench
  input  wire logic [6:0]        ok_v,
  input  wire logic              son_on,
  input  wire logic              son_inv,
  input  wire logic              flag_on,
  input  wire logic              flag_inv,
  // pin levels
  output wire pgp_pkg::pgp_sup_t sup_ok,
  output wire logic              supply_on_request,
  output wire logic              external_flag_input
);
  // a source wired active low shows the inverse of its state
  assign sup_ok = ok_v;
  assign supply_on_request = son_on ^ son_inv;
  assign external_flag_input = flag_on ^ flag_inv;
endmodule : pgp_far_side
`default_nettype wire

// *** sim/power_good_pin_polarity_tb.sv ***
`timescale 1ns/100ps
`default_nettype none
module power_good_pin_polarity_tb;
  logic              hclk = 0, hresetn = 0, hsel = 0, hwrite = 0;
  logic [31:0]       haddr = 0, hwdata = 0, hrdata, rq;
  logic [1:0]        htrans = 0;
  logic [2:0]        hsize = 3'h2;
  logic [7:0]        fault_flags = 0, flag_ignored = 0;
  logic [6:0]        ok_v = 0;
  logic              gate_on_request = 0, son_on = 0, son_inv = 0;
  logic              flag_on = 0, flag_inv = 0, hreadyout, hresp, irq;
  logic              power_good_primary, power_good_secondary;
  logic              fet_gate, flag_in_active;
  wire pgp_pkg::pgp_sup_t sup_ok;
  wire               supply_on_request, external_flag_input;
  int                err_total = 0, num_checks = 0;

  always #2 hclk = ~hclk;

  // short tick keeps the long debounce counts quick
  pgp_top #(.TICK_CYCLES(4)) dut (.hclk, .hresetn, .hsel, .haddr, .htrans,
    .hwrite, .hsize, .hwdata, .hready(hreadyout), .hreadyout, .hresp,
    .hrdata, .sup_ok, .supply_on_request, .external_flag_input,
    .fault_flags, .flag_ignored, .gate_on_request, .power_good_primary,
    .power_good_secondary, .fet_gate, .flag_in_active, .irq);
  pgp_far_side u_far (.ok_v, .son_on, .son_inv, .flag_on, .flag_inv,
    .sup_ok, .supply_on_request, .external_flag_input);

  task automatic cyc(input int n);
    repeat (n) @(posedge hclk);
  endtask : cyc

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e)
    begin
      err_total++;
      $display("[FAIL] %s exp %h got %h", n, e, g);
    end
  endtask : chk

  // one single transfer; idle edges after it let a write land
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    hwrite <= w;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rq = hrdata;
    cyc(2);
  endtask : bus

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask : wr

  task automatic rdc(input string n, input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(n, e, rq);
  endtask : rdc

  task automatic t_regs;
    rdc("pol rst", 8'h00, 32'h0);
    rdc("status rst", 8'h04, 32'h0);
    rdc("mask rst", 8'h08, 32'h0);
    wr(8'h00, 32'ha5);
    rdc("pol rw", 8'h00, 32'ha5);
    wr(8'h10, 32'hff);
    rdc("unmapped", 8'h10, 32'h0);
    wr(8'h00, 32'h0);
    $display("regs done");
  endtask : t_regs

  task automatic t_pol;
    gate_on_request <= 1'b1;
    cyc(2);
    chk("gate high", 1, fet_gate);
    wr(8'h00, 32'h02);
    chk("gate low", 0, fet_gate);
    flag_on <= 1'b1;
    cyc(6);
    chk("flag high", 1, flag_in_active);
    wr(8'h00, 32'h04);
    flag_inv <= 1'b1;
    cyc(6);
    chk("flag inv on", 1, flag_in_active);
    flag_on <= 1'b0;
    cyc(6);
    chk("flag inv off", 0, flag_in_active);
    wr(8'h00, 32'h0);
    son_on <= 1'b1;
    cyc(6);
    // state word: off, conditions low, flag pin high and active high
    rdc("son high", 8'h0c, 32'h0000_000c);
    chk("son high bit", 32'h4, rq & 32'h4);
    wr(8'h00, 32'h01);
    son_inv <= 1'b1;
    cyc(6);
    rdc("son inv", 8'h0c, 32'h0000_000c);
    chk("son inv bit", 32'h4, rq & 32'h4);
    son_on <= 1'b0;
    cyc(6);
    rdc("son off", 8'h0c, 32'h0000_0008);
    chk("son off bit", 32'h0, rq & 32'h4);
    son_inv <= 1'b0;
    flag_inv <= 1'b0;
    wr(8'h00, 32'h0);
    $display("polarity done");
  endtask : t_pol

  task automatic t_pg2;
    fault_flags <= 8'h01;
    flag_ignored <= 8'h01;
    cyc(3);
    chk("pg2 any", 1, power_good_secondary);
    wr(8'h00, 32'h08);
    chk("pg2 ignored", 0, power_good_secondary);
    flag_ignored <= 8'h00;
    cyc(3);
    chk("pg2 kept", 1, power_good_secondary);
    fault_flags <= 8'h00;
    wr(8'h00, 32'h0);
    $display("secondary done");
  endtask : t_pg2

  task automatic t_pg1;
    wr(8'h00, 32'hf0);
    son_on <= 1'b1;
    for (int i = 0; i < 7; i++)
    begin
      ok_v <= ~(7'h1 << i);
      cyc(10);
      chk("pg1 one bad", 0, power_good_primary);
    end
    ok_v <= 7'h7f;
    cyc(10);
    chk("pg1 no delay", 1, power_good_primary);
    ok_v <= 7'h0;
    cyc(6);
    wr(8'h04, 32'hf);
    wr(8'h08, 32'h1);
    wr(8'h00, 32'h0);
    ok_v <= 7'h7f;
    cyc(1200);
    chk("pg1 320 early", 0, power_good_primary);
    cyc(100);
    chk("pg1 320", 1, power_good_primary);
    chk("irq set", 1, irq);
    wr(8'h04, 32'h1);
    chk("irq clear", 0, irq);
    son_on <= 1'b0;
    cyc(1200);
    chk("pg1 off early", 1, power_good_primary);
    cyc(100);
    chk("pg1 off", 0, power_good_primary);
    wr(8'h00, 32'ha0);
    son_on <= 1'b1;
    cyc(2350);
    chk("pg1 600 early", 0, power_good_primary);
    cyc(100);
    chk("pg1 600", 1, power_good_primary);
    ok_v <= 7'h7e;
    cyc(6);
    chk("pg1 fault", 0, power_good_primary);
    // 200 ms code: 200 ticks of 4 cycles after the pins settle
    wr(8'h00, 32'h10);
    ok_v <= 7'h7f;
    cyc(760);
    chk("pg1 200 early", 0, power_good_primary);
    cyc(60);
    chk("pg1 200", 1, power_good_primary);
    $display("primary done");
  endtask : t_pg1

  task automatic final_report;
    $display("checks %0d errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : final_report

  initial
  begin
    cyc(2);
    hresetn <= 1'b1;
    t_regs();
    t_pol();
    t_pg2();
    t_pg1();
    final_report();
  end

  // tests take about 6100 cycles; the limit allows over eight times that
  initial
  begin
    #200000;
    err_total++;
    final_report();
  end
endmodule : power_good_pin_polarity_tb

bind pgp_top pgp_top_asserts u_chk (.hclk, .hresetn, .hsel, .htrans,
  .hwrite, .hready, .hreadyout, .hresp, .hrdata, .sup_ok,
  .external_flag_input, .fault_flags, .flag_ignored, .gate_on_request,
  .power_good_primary, .power_good_secondary, .fet_gate, .flag_in_active);
`default_nettype wire
